// *** hw/i2ct_cfg.svh ***
// i2ct_cfg.svh: constants for the i2c target link and its controller end
// assumes: included by bare name from every design file that needs them
`ifndef I2CT_CFG_SVH
`define I2CT_CFG_SVH
// ----------------------------------------
// addressing
// ----------------------------------------
`define I2CT_ADDR_HI 4'h9
`define I2CT_BCAST 7'h47
`define I2CT_GCALL 8'h00
`define I2CT_SWRST 8'h06
`define I2CT_STRAP_GND 3'h0
`define I2CT_STRAP_VDD 3'h1
`define I2CT_STRAP_SDA 3'h2
`define I2CT_STRAP_SCL 3'h3
// ----------------------------------------
// byte positions within a frame
// ----------------------------------------
`define I2CT_BYTE_ADDR 3'h0
`define I2CT_BYTE_CMD 3'h1
`define I2CT_BYTE_UPPER 3'h2
`define I2CT_BYTE_LOWER 3'h3
`define I2CT_BYTE_RD_HI 3'h3
`define I2CT_BYTE_RD_LO 3'h4
// ----------------------------------------
// timing
// ----------------------------------------
`define I2CT_CLK_MHZ 200
`define I2CT_BIT_NS 1000
`define I2CT_QTR_CYC ((`I2CT_BIT_NS * `I2CT_CLK_MHZ) / (4 * 1000))
`endif

// *** hw/i2ct_ctrl.sv ***
// i2ct_ctrl: i2c controller end issuing writes, reads and general call
// assumes: one target on the bus, no clock stretching
`timescale 1ns/10ps
`include "i2ct_cfg.svh"
module i2ct_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  i2ct_if.ctrl bus,
  input wire logic go,
  input wire logic op_read,
  input wire logic op_gcall,
  input wire logic [6:0] tgt_addr,
  input wire i2ct_pkg::i2ct_byte_t reg_cmd,
  input wire i2ct_pkg::i2ct_word_t wdata,
  output logic busy,
  output logic done,
  output logic nack,
  output i2ct_pkg::i2ct_word_t rdata
);
  import i2ct_pkg::*;
  localparam logic [7:0] QTR = 8'((`I2CT_QTR_CYC) - 1);
  logic sda_s;
  i2ct_sync #(.W(1)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d(bus.sda),
    .rst_val(1'b1),
    .q(sda_s)
  );
  i2ct_cst_t state_q;
  logic [7:0] cnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [2:0] idx_q, last;
  logic rd_q, gc_q, nk_q, scl_oe_q, sda_oe_q, tick, rx;
  i2ct_byte_t txb, rsh_q;
  logic [6:0] addr_q;
  i2ct_byte_t cmd_q;
  i2ct_word_t wd_q;
  assign tick = cnt_q == QTR;
  assign rx = rd_q && idx_q >= `I2CT_BYTE_RD_HI;
  assign last = gc_q ? `I2CT_BYTE_CMD : (rd_q ? `I2CT_BYTE_RD_LO : `I2CT_BYTE_LOWER);
  // ----------------------------------------
  // byte to send at each position
  // ----------------------------------------
  always_comb begin
    txb = 8'h00;
    if (gc_q) begin
      txb = (idx_q == `I2CT_BYTE_ADDR) ? `I2CT_GCALL : `I2CT_SWRST;
    end else if (idx_q == `I2CT_BYTE_ADDR) begin
      txb = {addr_q, 1'b0};
    end else if (idx_q == `I2CT_BYTE_CMD) begin
      txb = cmd_q;
    end else if (rd_q) begin
      txb = {addr_q, 1'b1};
    end else if (idx_q == `I2CT_BYTE_UPPER) begin
      txb = wd_q[15:8];
    end else begin
      txb = wd_q[7:0];
    end
  end
  // ----------------------------------------
  // quarter-bit timebase, scl made by division
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || state_q == C_IDLE || tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= C_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 3'h0;
      rd_q <= 1'b0;
      gc_q <= 1'b0;
      nk_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rsh_q <= 8'h00;
      addr_q <= 7'h00;
      cmd_q <= 8'h00;
      wd_q <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (state_q == C_IDLE) begin
        if (go) begin
          state_q <= C_START;
          ph_q <= 2'h0;
          rd_q <= op_read & ~op_gcall;
          gc_q <= op_gcall;
          addr_q <= tgt_addr;
          cmd_q <= reg_cmd;
          wd_q <= wdata;
          nk_q <= 1'b0;
          idx_q <= 3'h0;
          bit_q <= 4'h0;
          busy <= 1'b1;
        end
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (state_q)
          C_START, C_RSTART: begin
            // sda moves only while scl is high for the condition itself
            if (ph_q == 2'h0) begin
              sda_oe_q <= 1'b0;
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              sda_oe_q <= 1'b1;
            end else begin
              scl_oe_q <= 1'b1;
              state_q <= C_BIT;
              bit_q <= 4'h0;
            end
          end
          C_BIT: begin
            if (ph_q == 2'h0) begin
              // data set up in the low phase
              if (bit_q < 4'h8) begin
                sda_oe_q <= ~rx & ~txb[3'(4'h7 - bit_q)];
              end else begin
                sda_oe_q <= rx && idx_q == `I2CT_BYTE_RD_HI;
              end
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              if (bit_q < 4'h8) begin
                rsh_q <= {rsh_q[6:0], sda_s};
              end else if (!rx && sda_s) begin
                nk_q <= 1'b1;
              end
            end else begin
              scl_oe_q <= 1'b1;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_q <= 4'h0;
                idx_q <= idx_q + 3'h1;
                if (rx && idx_q == `I2CT_BYTE_RD_HI) begin
                  rdata[15:8] <= rsh_q;
                end else if (rx) begin
                  rdata[7:0] <= rsh_q;
                end
                if (nk_q || idx_q == last) begin
                  state_q <= C_STOP;
                end else if (rd_q && idx_q == `I2CT_BYTE_CMD) begin
                  state_q <= C_RSTART;
                end
              end
            end
          end
          C_STOP: begin
            if (ph_q == 2'h0) begin
              sda_oe_q <= 1'b1;
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              sda_oe_q <= 1'b0;
            end else begin
              state_q <= C_IDLE;
              busy <= 1'b0;
              done <= 1'b1;
              nack <= nk_q;
            end
          end
          default: begin
            state_q <= C_IDLE;
          end
        endcase
      end
    end
  end
  assign bus.scl_oe_c = scl_oe_q;
  assign bus.sda_oe_c = sda_oe_q;
endmodule

// *** hw/i2ct_if.sv ***
// i2ct_if: open-drain scl/sda wires between controller and target
// assumes: pull-ups modelled here; a high enable pulls the line low
`timescale 1ns/10ps
interface i2ct_if;
  logic scl_oe_c;
  logic sda_oe_c;
  logic sda_oe_t;
  logic scl;
  logic sda;
  // ----------------------------------------
  // wired-and resolution
  // ----------------------------------------
  assign scl = ~scl_oe_c;
  assign sda = ~(sda_oe_c | sda_oe_t);
  modport ctrl (output scl_oe_c, output sda_oe_c, input scl, input sda);
  modport tgt (output sda_oe_t, input scl, input sda);
endinterface

// *** hw/i2ct_pkg.sv ***
// i2ct_pkg: types shared by both ends of the i2c link
// assumes: compiled before every other design file
package i2ct_pkg;
  typedef logic [7:0] i2ct_byte_t;
  typedef logic [15:0] i2ct_word_t;
  typedef enum logic [4:0] {
    T_IDLE = 5'h01,
    T_RX = 5'h02,
    T_RACK = 5'h04,
    T_TX = 5'h08,
    T_TACK = 5'h10
  } i2ct_tst_t;
  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_START = 5'h02,
    C_BIT = 5'h04,
    C_RSTART = 5'h08,
    C_STOP = 5'h10
  } i2ct_cst_t;
endpackage

// *** hw/i2ct_sync.sv ***
// i2ct_sync: two-flop synchroniser for levels from outside mclk
// assumes: inputs change slowly against mclk
`timescale 1ns/10ps
module i2ct_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // reset value is a constant tie-off at every instance
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= rst_val;
      q <= rst_val;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// *** hw/i2ct_target.sv ***
// i2ct_target: i2c target end with register write and read ports
// assumes: scl and sda sampled on mclk, far faster than the bit rate
// Operation
// - detect start: sda falls, scl high
// - detect stop: sda rises, scl high
// - sda changes only while scl low
// - ack only on own address match
// - address lsb: 0 write, 1 read
// - eight bits then receiver acknowledge
// - stop releases bus; wait start, match
// - acknowledge every written byte
// - write: address, command, upper, lower
// - update only after both data bytes
// - apply write at ack falling edge
// - address upper bits fixed 1001
// - strap pin sets low address bits
// - sample strap during each first byte
// - accept broadcast write address too
// - broadcast never starts a read
// - read: address, command, both acked
// - repeated start, read address, then transmit
// - send upper byte, then lower byte
// - general call 00, 06 soft resets
// - same protocol at all bit rates
`timescale 1ns/10ps
`include "i2ct_cfg.svh"
module i2ct_target (
  input wire logic mclk,
  input wire logic sys_rst,
  i2ct_if.tgt bus,
  input wire logic address_strap_pin,
  input wire i2ct_pkg::i2ct_word_t rd_data,
  output i2ct_pkg::i2ct_byte_t rd_cmd,
  output i2ct_pkg::i2ct_byte_t wr_cmd,
  output i2ct_pkg::i2ct_word_t wr_data,
  output logic wr_valid,
  output logic soft_rst
);
  import i2ct_pkg::*;
  // ----------------------------------------
  // line sampling and conditions
  // ----------------------------------------
  logic scl_s, sda_s, strap_s, scl_p_q, sda_p_q;
  i2ct_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d({bus.scl, bus.sda, address_strap_pin}),
    .rst_val(3'h7),
    .q({scl_s, sda_s, strap_s})
  );
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  // edges come from the sampled scl, so any bit rate up to the clock limit works
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // ----------------------------------------
  // state
  // ----------------------------------------
  i2ct_tst_t state_q;
  logic [2:0] bit_q, byte_q;
  logic ph_q, ack_q, rd_q, gc_q, rst_pend_q, hl_q, sda_oe_q;
  logic wr_pend_q;
  i2ct_byte_t sh_q, upper_q, lower_q, cmd_q, low_tx_q;
  logic not_lo_q, not_hi_q, not_sda_q, not_scl_q;
  logic [2:0] addr_lo;
  i2ct_byte_t rxb;
  logic own_c, bc_c, gcall_c;
  assign rxb = {sh_q[6:0], sda_s};
  // strap decode from what the pin did during the address byte
  always_comb begin
    if (!not_lo_q) begin
      addr_lo = `I2CT_STRAP_GND;
    end else if (!not_hi_q) begin
      addr_lo = `I2CT_STRAP_VDD;
    end else if (!not_scl_q) begin
      addr_lo = `I2CT_STRAP_SCL;
    end else begin
      addr_lo = `I2CT_STRAP_SDA;
    end
  end
  assign own_c = rxb[7:1] == {`I2CT_ADDR_HI, addr_lo};
  assign bc_c = (rxb[7:1] == `I2CT_BCAST) & ~rxb[0];
  assign gcall_c = rxb == `I2CT_GCALL;
  // ----------------------------------------
  // strap sampling
  // ----------------------------------------
  // scl-tied straps only show as such if both edges are watched
  always_ff @(posedge mclk) begin
    if (sys_rst || start_c) begin
      not_lo_q <= 1'b0;
      not_hi_q <= 1'b0;
      not_sda_q <= 1'b0;
      not_scl_q <= 1'b0;
    end else if (state_q == T_RX && byte_q == `I2CT_BYTE_ADDR && (scl_rise || scl_fall)) begin
      if (strap_s) begin
        not_lo_q <= 1'b1;
      end else begin
        not_hi_q <= 1'b1;
      end
      if (strap_s != scl_s) begin
        not_scl_q <= 1'b1;
      end
      if (scl_rise && strap_s != sda_s) begin
        not_sda_q <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= T_IDLE;
      bit_q <= 3'h0;
      byte_q <= 3'h0;
      ph_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      gc_q <= 1'b0;
      rst_pend_q <= 1'b0;
      hl_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
      sh_q <= 8'h00;
      upper_q <= 8'h00;
      lower_q <= 8'h00;
      cmd_q <= 8'h00;
      low_tx_q <= 8'h00;
    end else if (start_c) begin
      // start or repeated start: a fresh address byte follows
      state_q <= T_RX;
      bit_q <= 3'h0;
      byte_q <= `I2CT_BYTE_ADDR;
      ph_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
      rst_pend_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= T_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        T_RX: begin
          if (scl_rise) begin
            sh_q <= rxb;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              ph_q <= 1'b0;
              state_q <= T_RACK;
              if (byte_q == `I2CT_BYTE_ADDR) begin
                // match decides whether we take part at all
                ack_q <= own_c | bc_c | gcall_c;
                rd_q <= own_c & rxb[0];
                gc_q <= gcall_c;
                if (!(own_c | bc_c | gcall_c)) begin
                  state_q <= T_IDLE;
                end
              end else if (gc_q) begin
                ack_q <= rxb == `I2CT_SWRST;
                rst_pend_q <= rxb == `I2CT_SWRST;
                if (rxb != `I2CT_SWRST) begin
                  state_q <= T_IDLE;
                end
              end else begin
                ack_q <= 1'b1;
                if (byte_q == `I2CT_BYTE_CMD) begin
                  cmd_q <= rxb;
                end else if (byte_q == `I2CT_BYTE_UPPER) begin
                  upper_q <= rxb;
                end else begin
                  lower_q <= rxb;
                  wr_pend_q <= 1'b1;
                end
              end
            end
          end
        end
        T_RACK: begin
          if (scl_fall && !ph_q) begin
            ph_q <= 1'b1;
            sda_oe_q <= ack_q;
          end else if (scl_rise && ph_q) begin
            rst_pend_q <= 1'b0;
          end else if (scl_fall && ph_q) begin
            wr_pend_q <= 1'b0;
            bit_q <= 3'h0;
            ph_q <= 1'b0;
            if (rd_q) begin
              // switch to transmit, both bytes held from one snapshot
              state_q <= T_TX;
              sh_q <= rd_data[15:8];
              low_tx_q <= rd_data[7:0];
              hl_q <= 1'b0;
              sda_oe_q <= ~rd_data[15];
            end else begin
              state_q <= T_RX;
              sda_oe_q <= 1'b0;
              // extra data pairs are further updates of the same register
              byte_q <= (byte_q == `I2CT_BYTE_LOWER) ? `I2CT_BYTE_UPPER : byte_q + 3'h1;
            end
          end
        end
        T_TX: begin
          if (scl_fall) begin
            sh_q <= {sh_q[6:0], 1'b0};
            sda_oe_q <= ~sh_q[6];
          end else if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_q <= T_TACK;
              ph_q <= 1'b0;
            end
          end
        end
        T_TACK: begin
          if (scl_fall && !ph_q) begin
            ph_q <= 1'b1;
            sda_oe_q <= 1'b0;
          end else if (scl_rise && ph_q) begin
            ack_q <= ~sda_s;
          end else if (scl_fall && ph_q) begin
            ph_q <= 1'b0;
            bit_q <= 3'h0;
            if (ack_q) begin
              // lower after upper, then the written upper_q and the held lower byte in turn if the controller keeps going
              state_q <= T_TX;
              hl_q <= ~hl_q;
              sh_q <= hl_q ? upper_q : low_tx_q;
              sda_oe_q <= hl_q ? ~upper_q[7] : ~low_tx_q[7];
            end else begin
              state_q <= T_IDLE;
            end
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------
  // user side outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_valid <= 1'b0;
      wr_cmd <= 8'h00;
      wr_data <= 16'h0000;
      rd_cmd <= 8'h00;
      soft_rst <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      soft_rst <= 1'b0;
      rd_cmd <= cmd_q;
      if (state_q == T_RACK && ph_q && scl_fall && wr_pend_q && !start_c && !stop_c) begin
        wr_valid <= 1'b1;
        wr_cmd <= cmd_q;
        wr_data <= {upper_q, lower_q};
      end
      if (state_q == T_RACK && ph_q && scl_rise && rst_pend_q && !start_c && !stop_c) begin
        soft_rst <= 1'b1;
      end
    end
  end
  assign bus.sda_oe_t = sda_oe_q;
endmodule

// *** verification/i2ct_link_monitor.sv ***
// i2ct_link_monitor: wire-level checks on the open-drain link
// assumes: fed straight from the link interface, one mclk domain
`timescale 1ns/10ps
module i2ct_link_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_oe_c,
  input wire logic sda_oe_c,
  input wire logic sda_oe_t,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, sel_q, rd_q, nack_q, idle_q;
  logic [3:0] bitn_q;
  logic [2:0] unit_q;
  logic [7:0] sh_q;
  logic start_w, stop_w, rise_w, fall_w, ackhi_w, form_w;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  assign rise_w = scl && !scl_q;
  assign fall_w = !scl && scl_q;
  assign ackhi_w = bitn_q == 4'h9 && scl && scl_q;
  // own address form, broadcast write or general call: the strap is not visible from here
  assign form_w = sh_q[7:3] == 5'h12 || sh_q == 8'h8e || sh_q == 8'h00;
  always_ff @(posedge mclk) begin
    scl_q <= sys_rst | scl;
    sda_q <= sys_rst | sda;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || start_w) begin
      bitn_q <= 4'h0;
      unit_q <= 3'h0;
    end else if (rise_w && bitn_q != 4'h9) begin
      bitn_q <= bitn_q + 4'h1;
    end else if (fall_w && bitn_q == 4'h9) begin
      bitn_q <= 4'h0;
      unit_q <= (unit_q == 3'h7) ? unit_q : unit_q + 3'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_q <= 8'h00;
    end else if (rise_w && bitn_q < 4'h8) begin
      sh_q <= {sh_q[6:0], sda};
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || start_w) begin
      sel_q <= 1'b0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (rise_w && bitn_q == 4'h8) begin
      if (unit_q == 3'h0) begin
        sel_q <= !sda;
        rd_q <= sh_q[0];
      end else if (sel_q && rd_q && sda) begin
        nack_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || stop_w) begin
      idle_q <= 1'b1;
    end else if (start_w) begin
      idle_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ack_addr_form: assert property (unit_q == 3'h0 && ackhi_w && sda_oe_t |-> form_w)
    else $error("address acknowledged for a foreign address");
  a_bcast_ack: assert property (unit_q == 3'h0 && ackhi_w && sh_q == 8'h8e |-> sda_oe_t)
    else $error("broadcast write address not acknowledged");
  a_write_byte_ack: assert property (unit_q != 3'h0 && sel_q && !rd_q && ackhi_w |-> sda_oe_t)
    else $error("written byte not acknowledged");
  a_read_no_ack: assert property (unit_q != 3'h0 && sel_q && rd_q && ackhi_w |-> !sda_oe_t)
    else $error("target drives sda in the controller acknowledge");
  a_nack_release: assert property (nack_q |-> !sda_oe_t)
    else $error("target drives sda after a missing acknowledge");
  a_ignore_other: assert property (!sel_q && unit_q != 3'h0 |-> !sda_oe_t)
    else $error("target drives sda while not addressed");
  a_idle_release: assert property (idle_q |-> !sda_oe_t)
    else $error("target drives sda between stop and start");
  a_drive_lag: assert property ($changed(sda_oe_t) |-> !scl && ($past(scl, 4) || $past(scl, 5)))
    else $error("target sda drive changed away from an scl fall");
endmodule

// *** verification/tb_i2c_target_register_access.sv ***
// tb_i2c_target_register_access: controller and target joined on one link
// assumes: design compiled first; 1 Mbps link, so each byte is ~1800 mclk
`timescale 1ns/10ps
module tb_i2c_target_register_access;
  import i2ct_pkg::*;
  logic mclk, sys_rst, go, op_read, op_gcall, strap, busy, done, nack, wr_valid, soft_rst;
  logic [6:0] tgt_addr;
  logic [1:0] strap_sel;
  i2ct_byte_t reg_cmd, rd_cmd, wr_cmd;
  i2ct_word_t wdata, rdata, rd_data, wr_data, last_wd;
  int mismatches, n_compared, n_wr, n_srst, lag, last_lag;
  i2ct_if link();
  // strap choices: ground, supply, data line, clock line
  assign strap = strap_sel == 2'h0 ? 1'b0 : strap_sel == 2'h1 ? 1'b1 :
                 strap_sel == 2'h2 ? link.sda : link.scl;
  // register model: readback is derived from the selected register
  assign rd_data = {rd_cmd ^ 8'h5a, rd_cmd};
  i2ct_ctrl i_i2ct_ctrl (.mclk(mclk), .sys_rst(sys_rst), .bus(link), .go(go),
    .op_read(op_read), .op_gcall(op_gcall), .tgt_addr(tgt_addr), .reg_cmd(reg_cmd),
    .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  i2ct_target i_i2ct_target (.mclk(mclk), .sys_rst(sys_rst), .bus(link),
    .address_strap_pin(strap), .rd_data(rd_data), .rd_cmd(rd_cmd), .wr_cmd(wr_cmd),
    .wr_data(wr_data), .wr_valid(wr_valid), .soft_rst(soft_rst));
  i2ct_link_monitor i_i2ct_link_monitor (.mclk(mclk), .sys_rst(sys_rst),
    .scl_oe_c(link.scl_oe_c), .sda_oe_c(link.sda_oe_c), .sda_oe_t(link.sda_oe_t),
    .scl(link.scl), .sda(link.sda));
  // ----------------------------------------
  // clock, output watchers, helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    lag = (link.scl === 1'b1) ? 0 : lag + 1;
    if (wr_valid === 1'b1) begin
      n_wr++;
      last_wd = wr_data;
      last_lag = lag;
    end
    if (soft_rst === 1'b1) n_srst++;
  end
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task xfer(input logic rd, input logic gc, input logic [6:0] a, input i2ct_byte_t c,
            input i2ct_word_t w);
    int k;
    @(negedge mclk);
    op_read = rd;
    op_gcall = gc;
    tgt_addr = a;
    reg_cmd = c;
    wdata = w;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    // the start sequence is under way one cycle after go is taken
    chk("busy", {15'h0000, busy}, 16'h0001);
    // bounded wait: a full read is well under 15000 cycles
    for (k = 0; k < 40000 && done !== 1'b1; k++) @(negedge mclk);
    chk("done", {15'h0000, done}, 16'h0001);
    chk("idle", {15'h0000, busy}, 16'h0000);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_strap;
    for (int s = 0; s < 4; s++) begin
      strap_sel = 2'(s);
      n_wr = 0;
      xfer(1'b0, 1'b0, {5'h12, 2'(s)}, 8'h10 + 8'(s), 16'ha5c3 ^ 16'(s));
      chk("nack own", {15'h0000, nack}, 16'h0000);
      chk("write count", 16'(n_wr), 16'h0001);
      chk("wr_cmd", {8'h00, wr_cmd}, {8'h00, 8'h10 + 8'(s)});
      chk("wr_data", last_wd, 16'ha5c3 ^ 16'(s));
      chk("update lag", 16'(last_lag >= 2 && last_lag <= 6), 16'h0001);
      xfer(1'b0, 1'b0, {5'h12, ~2'(s)}, 8'h20, 16'h0f0f);
      chk("nack foreign", {15'h0000, nack}, 16'h0001);
      chk("foreign write", 16'(n_wr), 16'h0001);
    end
    $display("strap test finished");
  endtask
  task t_read;
    strap_sel = 2'h0;
    n_wr = 0;
    xfer(1'b1, 1'b0, 7'h48, 8'h2c, 16'h0000);
    chk("nack read", {15'h0000, nack}, 16'h0000);
    chk("rd_cmd", {8'h00, rd_cmd}, 16'h002c);
    chk("rdata", rdata, {8'h2c ^ 8'h5a, 8'h2c});
    chk("read writes", 16'(n_wr), 16'h0000);
    $display("read test finished");
  endtask
  task t_bcast;
    strap_sel = 2'h1;
    n_wr = 0;
    xfer(1'b0, 1'b0, 7'h47, 8'h30, 16'h1234);
    chk("nack bcast", {15'h0000, nack}, 16'h0000);
    chk("bcast data", last_wd, 16'h1234);
    xfer(1'b1, 1'b0, 7'h47, 8'h30, 16'h0000);
    chk("nack bcast read", {15'h0000, nack}, 16'h0001);
    chk("bcast writes", 16'(n_wr), 16'h0001);
    $display("broadcast test finished");
  endtask
  task t_gcall;
    n_srst = 0;
    n_wr = 0;
    xfer(1'b0, 1'b1, 7'h00, 8'h00, 16'h0000);
    chk("nack gcall", {15'h0000, nack}, 16'h0000);
    chk("soft reset", 16'(n_srst), 16'h0001);
    chk("gcall writes", 16'(n_wr), 16'h0000);
    $display("general call test finished");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    // about 65000 cycles of traffic are expected
    #450000;
    mismatches++;
    conclude();
  end
  initial begin
    {go, op_read, op_gcall, tgt_addr, reg_cmd, wdata, strap_sel} = '0;
    mismatches = 0;
    n_compared = 0;
    lag = 0;
    sys_rst = 1'b1;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_strap();
    t_read();
    t_bcast();
    t_gcall();
    conclude();
  end
endmodule
